/* common/nand_host_pkg.sv */
// package: command codes, address layout, status bits, registers and timing for the nand host
package nand_host_pkg;
  // command codes
  localparam logic [7:0] CMD_DATA_IN   = 8'h80;
  localparam logic [7:0] CMD_READ_LOW  = 8'h00;
  localparam logic [7:0] CMD_READ_HIGH = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_RESET     = 8'hff;
  localparam logic [7:0] CMD_PROG_TRUE = 8'h10;
  localparam logic [7:0] CMD_PROG_DUMMY = 8'h11;
  localparam logic [7:0] CMD_PROG_MULTI = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hd0;
  localparam logic [7:0] CMD_STATUS1   = 8'h70;
  localparam logic [7:0] CMD_STATUS2   = 8'h71;
  localparam logic [7:0] CMD_ID1       = 8'h90;
  localparam logic [7:0] CMD_ID2       = 8'h91;
  // array geometry
  localparam int PAGE_BYTES      = 528;
  localparam int MAIN_BYTES      = 512;
  localparam int PAGES_PER_BLOCK = 32;
  localparam int BLOCKS          = 4096;
  localparam int DISTRICTS       = 4;
  localparam int MAX_MULTI_BLOCKS = 4;
  localparam int MAX_PAGE_PROGRAMS = 3;
  localparam int ADDR_CYCLES     = 4;
  // status byte bits
  localparam int STAT_FAIL  = 0;
  localparam int STAT_READY = 6;
  localparam int STAT_WPOFF = 7;
  // host register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_DATA   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // ctrl field positions
  localparam int CTRL_CMD_LSB  = 0;
  localparam int CTRL_KIND_LSB = 8;
  localparam int CTRL_GO       = 12;
  localparam int CTRL_WP       = 13;
  localparam int CTRL_KEEP_CE  = 14;
  // operation kinds
  localparam logic [3:0] KIND_CMD      = 4'h0;
  localparam logic [3:0] KIND_CMD_ADDR = 4'h1;
  localparam logic [3:0] KIND_WRITE    = 4'h2;
  localparam logic [3:0] KIND_READ     = 4'h3;
  localparam logic [3:0] KIND_WAIT     = 4'h4;
  localparam logic [3:0] KIND_ID       = 4'h5;
  // timing in ns and derived cycles at 100 mhz
  localparam int CLK_NS            = 10;
  localparam int STROBE_LOW_NS     = 40;
  localparam int STROBE_HIGH_NS    = 30;
  localparam int deselect_hold_time = 100;
  localparam int WP_SETUP_NS       = 100;
  localparam int BUSY_START_NS     = 200;
  localparam int STROBE_LOW_CYC    = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HIGH_CYC   = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int DESELECT_CYC      = (deselect_hold_time + CLK_NS - 1) / CLK_NS;
  localparam int WP_SETUP_CYC      = (WP_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_START_CYC    = (BUSY_START_NS + CLK_NS - 1) / CLK_NS;
endpackage : nand_host_pkg

/* hdl/nand_host.sv */
// nand flash host controller driven over classic wishbone
// Function
// RULE_01: command byte latched with cle, we rising
// RULE_02: address byte latched with ale, we rising
// RULE_03: data byte latched, latches low, wp high
// RULE_04: chip select ignored by device while busy
// RULE_05: keep chip select low during array read
// RULE_06: each read strobe fall gives next byte
// RULE_07: write guard low blocks program and erase
// RULE_08: ready_busy_n low during busy operations
// RULE_09: pages 528 bytes, 32 pages, 4096 blocks
// RULE_10: four address cycles, low bits first
// RULE_11: fourth address cycle lines two-eight low
// RULE_12: bit 8 chosen by 00h or 01h
// RULE_13: bits 14-25 block, 9-13 page
// RULE_14: device decodes the listed command codes
// RULE_15: only reset and status while busy
// RULE_16: command msb on line eight
// RULE_17: read mode persists after read command
// RULE_18: device drives bus only during read low
// RULE_19: chip select high 100 ns ends read
// RULE_20: multi program busy up to 1000 us
// RULE_21: dummy program busy up to 10 us
// RULE_22: at most three programs per page; the host counts only repeat programs of the last page programmed
// RULE_23: multi program targets at most four blocks
// RULE_24: status 70h bit layout
// RULE_25: district is block modulo four
// RULE_26: reset aborts and returns ready
// RULE_27: id bytes follow id command and address
`timescale 1ns/1ns
`default_nettype none
module nand_host #(
  parameter int unsigned STROBE_LOW  = nand_host_pkg::STROBE_LOW_CYC,
  parameter int unsigned STROBE_HIGH = nand_host_pkg::STROBE_HIGH_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // nand pins
  output logic             cle_o,
  output logic             ale_o,
  output logic             chip_select_n_o,
  output logic             write_strobe_n_o,
  output logic             read_strobe_n_o,
  output logic             write_guard_n_o,
  output logic      [7:0]  io_o,
  output logic             io_oe_o,
  input  wire logic [7:0]  io_i,
  input  wire logic        ready_busy_n_i
);
  initial begin
    if (STROBE_LOW < 3 || STROBE_LOW > 255 || STROBE_HIGH < 2 || STROBE_HIGH > 255)
      $error("nand_host: strobe widths out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_DATA_W, S_DATA_R, S_WAIT_BUSY, S_WAIT_READY, S_DESELECT, S_DONE
  } state_type;

  state_type   state;
  logic [7:0]  cmd;
  logic [3:0]  kind;
  logic        keep_ce;
  logic        guard;
  logic [25:0] addr;
  logic [2:0]  addr_cnt;
  logic [7:0]  wr_data;
  logic        wr_full;
  logic [7:0]  rd_data;
  logic        rd_full;
  logic [7:0]  timer;
  logic        phase;
  logic        ready_meta;
  logic        ready_s2;
  logic        ready_s3;
  logic        ready;
  logic        busy_flag;
  logic [16:0] prog_page;
  logic [1:0]  prog_cnt;
  logic [1:0]  dummy_cnt;

  // pin input synchroniser: change accepted once stages two and three agree
  always_ff @(posedge clk_i) begin
    ready_meta <= ready_busy_n_i;
    ready_s2   <= ready_meta;
    ready_s3   <= ready_s2;
    if (rst_i)
      ready <= 1'b1;
    else if (ready_s2 == ready_s3)
      ready <= ready_s3; // RULE_08
  end

  // wishbone decode
  wire         bus_req   = cyc_i && stb_i && !ack_o;
  wire         wr_ctrl   = bus_req && we_i && adr_i == nand_host_pkg::REG_CTRL && sel_i[1];
  wire         wr_addr   = bus_req && we_i && adr_i == nand_host_pkg::REG_ADDR && sel_i == 4'hf;
  wire         wr_dat    = bus_req && we_i && adr_i == nand_host_pkg::REG_DATA && sel_i[0];
  wire         rd_dat    = bus_req && !we_i && adr_i == nand_host_pkg::REG_DATA;
  wire         go        = wr_ctrl && dat_i[nand_host_pkg::CTRL_GO] && state == S_IDLE;
  wire         idle      = state == S_IDLE;
  wire [3:0]   go_kind   = dat_i[11:8];
  wire [31:0]  ctrl_word = {17'h0, keep_ce, guard, 1'b0, 4'(kind), cmd};
  wire [31:0]  stat_word = {22'h0, busy_flag, ready, rd_full, wr_full, 2'h0, 4'(state)};
  wire [31:0]  rd_word   = (adr_i == nand_host_pkg::REG_CTRL)   ? ctrl_word :
                           (adr_i == nand_host_pkg::REG_ADDR)   ? {6'h0, addr} :
                           (adr_i == nand_host_pkg::REG_DATA)   ? {24'h0, rd_data} :
                           (adr_i == nand_host_pkg::REG_STATUS) ? stat_word : 32'h0;

  // address cycle byte: 0-7, 9-16, 17-24, then bit 25 with other lines low
  wire [7:0]   addr_byte = (addr_cnt == 3'd0) ? addr[7:0] :
                           (addr_cnt == 3'd1) ? addr[16:9] :
                           (addr_cnt == 3'd2) ? addr[24:17] : {7'h0, addr[25]}; // RULE_10 RULE_11 RULE_13
  wire [2:0]   addr_last = (kind == nand_host_pkg::KIND_ID) ? 3'd0 : 3'(nand_host_pkg::ADDR_CYCLES - 1);
  wire         timer_end = timer == 8'd0;
  wire         strobe_lo = !phase;
  wire [7:0]   low_cnt   = 8'(STROBE_LOW - 1);
  wire [7:0]   high_cnt  = 8'(STROBE_HIGH - 1);
  wire         cmd_end   = state == S_CMD && timer_end && phase;
  wire         prog_stop = (cmd == nand_host_pkg::CMD_PROG_TRUE || cmd == nand_host_pkg::CMD_PROG_MULTI) &&
                           prog_page == addr[25:9] &&
                           prog_cnt == 2'(nand_host_pkg::MAX_PAGE_PROGRAMS); // RULE_22
  wire         dummy_stop = cmd == nand_host_pkg::CMD_PROG_DUMMY &&
                            dummy_cnt == 2'(nand_host_pkg::MAX_MULTI_BLOCKS - 1); // RULE_23
  // only reset and status may be sent while the device is busy
  wire         cmd_ok    = (ready || cmd == nand_host_pkg::CMD_RESET ||
                           cmd == nand_host_pkg::CMD_STATUS1 ||
                           cmd == nand_host_pkg::CMD_STATUS2) && !prog_stop && !dummy_stop; // RULE_15
  wire         cmd_prog  = cmd == nand_host_pkg::CMD_PROG_TRUE || cmd == nand_host_pkg::CMD_PROG_DUMMY ||
                           cmd == nand_host_pkg::CMD_PROG_MULTI || cmd == nand_host_pkg::CMD_ERASE_GO;
  wire         cmd_rdmode = cmd == nand_host_pkg::CMD_READ_LOW || cmd == nand_host_pkg::CMD_READ_HIGH ||
                            cmd == nand_host_pkg::CMD_READ_SPARE; // RULE_17
  wire         expect_busy = cmd_prog || cmd == nand_host_pkg::CMD_RESET ||
                             (cmd_rdmode && kind == nand_host_pkg::KIND_CMD_ADDR);

  // wishbone registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      dat_o   <= 32'h0;
      cmd     <= 8'h0;
      kind    <= 4'h0;
      keep_ce <= 1'b0;
      guard   <= 1'b0;
      addr    <= 26'h0;
      wr_data <= 8'h0;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? rd_word : 32'h0;
      if (wr_ctrl && idle) begin
        cmd     <= dat_i[7:0];
        kind    <= dat_i[11:8];
        guard   <= dat_i[nand_host_pkg::CTRL_WP]; // RULE_07
        keep_ce <= dat_i[nand_host_pkg::CTRL_KEEP_CE];
      end
      if (wr_addr && idle)
        addr <= dat_i[25:0];
      if (wr_dat && !wr_full)
        wr_data <= dat_i[7:0];
    end
  end

  // byte handshake flags; set wins over clear: software set of wr_full, hardware set of rd_full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_full <= 1'b0;
      rd_full <= 1'b0;
    end else begin
      if (wr_dat)
        wr_full <= 1'b1;
      else if (state == S_DATA_W && !strobe_lo && timer_end)
        wr_full <= 1'b0;
      if (state == S_DATA_R && !strobe_lo && timer_end)
        rd_full <= 1'b1;
      else if (rd_dat)
        rd_full <= 1'b0;
    end
  end

  // page program and multi-block bookkeeping, taken as a command strobe ends
  always_ff @(posedge clk_i) begin
    if (rst_i || (cmd_end && cmd == nand_host_pkg::CMD_ERASE_GO)) begin
      prog_page <= 17'h0;
      prog_cnt  <= 2'h0;
      dummy_cnt <= 2'h0;
    end else if (cmd_end && cmd == nand_host_pkg::CMD_PROG_DUMMY) begin
      dummy_cnt <= dummy_cnt + 2'h1; // RULE_23
    end else if (cmd_end && (cmd == nand_host_pkg::CMD_PROG_TRUE || cmd == nand_host_pkg::CMD_PROG_MULTI)) begin
      dummy_cnt <= 2'h0;
      prog_page <= addr[25:9];
      prog_cnt  <= (prog_page == addr[25:9]) ? prog_cnt + 2'h1 : 2'h1; // RULE_22
    end
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state            <= S_IDLE;
      timer            <= 8'h0;
      phase            <= 1'b0;
      addr_cnt         <= 3'h0;
      busy_flag        <= 1'b0;
      rd_data          <= 8'h0;
      cle_o            <= 1'b0;
      ale_o            <= 1'b0;
      chip_select_n_o  <= 1'b1;
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o  <= 1'b1;
      write_guard_n_o  <= 1'b0;
      io_o             <= 8'h0;
      io_oe_o          <= 1'b0;
    end else begin
      write_guard_n_o <= guard; // RULE_07
      if (!timer_end)
        timer <= timer - 8'd1;
      case (state)
        S_IDLE: begin
          busy_flag <= 1'b0;
          if (!keep_ce)
            chip_select_n_o <= 1'b1; // RULE_19
          if (go && go_kind == nand_host_pkg::KIND_WAIT) begin
            state <= S_WAIT_READY;
          end else if (go && (go_kind == nand_host_pkg::KIND_WRITE || go_kind == nand_host_pkg::KIND_READ)) begin
            chip_select_n_o <= 1'b0;
            phase <= 1'b0;
            timer <= 8'(nand_host_pkg::WP_SETUP_CYC);
            state <= (go_kind == nand_host_pkg::KIND_WRITE) ? S_DATA_W : S_DATA_R;
          end else if (go) begin
            chip_select_n_o <= 1'b0;
            phase <= 1'b0;
            addr_cnt <= 3'h0;
            timer <= 8'(nand_host_pkg::WP_SETUP_CYC);
            state <= S_CMD;
          end
        end
        S_CMD: begin
          if (!cmd_ok) begin
            state <= S_DONE;
          end else if (timer_end && !phase) begin
            cle_o <= 1'b1; // RULE_01
            ale_o <= 1'b0;
            io_o  <= cmd; // RULE_16
            io_oe_o <= 1'b1;
            write_strobe_n_o <= 1'b0;
            phase <= 1'b1;
            timer <= low_cnt;
          end else if (timer_end && phase) begin
            write_strobe_n_o <= 1'b1; // RULE_01
            phase <= 1'b0;
            timer <= high_cnt;
            state <= (kind == nand_host_pkg::KIND_CMD_ADDR || kind == nand_host_pkg::KIND_ID) ?
                     S_ADDR : (expect_busy ? S_WAIT_BUSY : S_DONE);
          end
        end
        S_ADDR: begin
          if (timer_end && !phase) begin
            cle_o <= 1'b0;
            ale_o <= 1'b1; // RULE_02
            io_o  <= (kind == nand_host_pkg::KIND_ID) ? 8'h0 : addr_byte; // RULE_27
            io_oe_o <= 1'b1;
            write_strobe_n_o <= 1'b0;
            phase <= 1'b1;
            timer <= low_cnt;
          end else if (timer_end && phase) begin
            write_strobe_n_o <= 1'b1; // RULE_02
            phase <= 1'b0;
            timer <= high_cnt;
            addr_cnt <= addr_cnt + 3'd1;
            if (addr_cnt == addr_last)
              state <= expect_busy ? S_WAIT_BUSY : S_DONE;
          end
        end
        S_DATA_W: begin
          if (timer_end && !phase && wr_full) begin
            cle_o <= 1'b0;
            ale_o <= 1'b0; // RULE_03
            io_o  <= wr_data;
            io_oe_o <= 1'b1;
            write_strobe_n_o <= 1'b0;
            phase <= 1'b1;
            timer <= low_cnt;
          end else if (timer_end && phase) begin
            write_strobe_n_o <= 1'b1; // RULE_03
            phase <= 1'b0;
            timer <= high_cnt;
            state <= S_DONE;
          end
        end
        S_DATA_R: begin
          if (timer_end && !phase && !rd_full) begin
            cle_o <= 1'b0;
            ale_o <= 1'b0;
            io_oe_o <= 1'b0; // RULE_18
            read_strobe_n_o <= 1'b0; // RULE_06
            phase <= 1'b1;
            timer <= low_cnt;
          end else if (timer_end && phase) begin
            rd_data <= io_i;
            read_strobe_n_o <= 1'b1;
            phase <= 1'b0;
            timer <= high_cnt;
            state <= S_DONE;
          end
        end
        S_WAIT_BUSY: begin
          cle_o <= 1'b0;
          ale_o <= 1'b0;
          io_oe_o <= 1'b0;
          busy_flag <= 1'b1;
          if (!phase) begin
            timer <= 8'(nand_host_pkg::BUSY_START_CYC);
            phase <= 1'b1;
          end else if (timer_end) begin
            phase <= 1'b0;
            state <= S_WAIT_READY;
          end
        end
        S_WAIT_READY: begin
          // chip select held low through an array read
          busy_flag <= !ready; // RULE_05 RULE_08
          if (ready)
            state <= S_DONE;
        end
        S_DONE: begin
          cle_o <= 1'b0;
          ale_o <= 1'b0;
          io_oe_o <= 1'b0;
          if (timer_end) begin
            if (!keep_ce) begin
              chip_select_n_o <= 1'b1;
              timer <= 8'(nand_host_pkg::DESELECT_CYC);
              state <= S_DESELECT;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_DESELECT: begin
          if (timer_end)
            state <= S_IDLE; // RULE_19
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule : nand_host
`default_nettype wire

/* bench/nand_host_checker.sv */
// checker: strobe, bus and reset relations at the nand host ports
`timescale 1ns/1ns
`default_nettype none
module nand_host_checker (
  // clock, reset, bus
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // nand pins
  input wire logic       cle_o,
  input wire logic       ale_o,
  input wire logic       chip_select_n_o,
  input wire logic       write_strobe_n_o,
  input wire logic       read_strobe_n_o,
  input wire logic       write_guard_n_o,
  input wire logic [7:0] io_o,
  input wire logic       io_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence low_rest;
    !write_strobe_n_o [*3] ##1 write_strobe_n_o;
  endsequence
  sequence data_cycle;
    !write_strobe_n_o && !cle_o && !ale_o;
  endsequence
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_we_width: assert property ($fell(write_strobe_n_o) |=> low_rest)
    else $error("write strobe width wrong");
  a_latch_hold: assert property ($rose(write_strobe_n_o) |-> $stable(io_o) && $stable(cle_o) && $stable(ale_o))
    else $error("bus moved at latch edge");
  a_data_guard: assert property (data_cycle |-> write_guard_n_o && io_oe_o)
    else $error("data byte without guard");
  a_we_drive: assert property (!write_strobe_n_o |-> io_oe_o && !chip_select_n_o && read_strobe_n_o)
    else $error("write strobe without drive");
  a_read_sel: assert property (!read_strobe_n_o |-> !chip_select_n_o && !io_oe_o && write_strobe_n_o)
    else $error("read strobe while driving");
  a_reset_idle: assert property ($fell(rst_i) |-> chip_select_n_o && write_strobe_n_o && read_strobe_n_o && !io_oe_o && !write_guard_n_o && !cle_o && !ale_o)
    else $error("pins not idle after reset");
endmodule : nand_host_checker
bind nand_host nand_host_checker chk_u (.*);
`default_nettype wire

/* bench/nand_dev_model.sv */
// behavioural nand device: commands, address cycles, page register, status, busy
`timescale 1ns/1ns
`default_nettype none
module nand_dev_model #(
  parameter int         BUSY_CYC = 40,
  parameter logic [7:0] MAKER_ID = 8'h3c  // arbitrary value
) (
  // busy timing
  input  wire logic       clk_i,
  // host pins
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic       write_guard_n_i,
  input  wire logic [7:0] io_i,
  // device pins
  output logic      [7:0] io_o,
  output logic            io_oe_o,
  output logic            ready_busy_n_o
);
  logic [7:0]  page [528] = '{default: 8'hff};
  logic [7:0]  mem [int];
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  a4 = 8'h00;
  logic [25:0] addr = '0;
  logic        fail = 1'b0;
  int          acyc = 0;
  int          col = 0;
  int          busy = 0;
  int          mode = 0;
  assign ready_busy_n_o = busy == 0;
  assign io_oe_o = !chip_select_n_i && !read_strobe_n_i;
  always @(posedge clk_i) if (busy > 0) busy <= busy - 1;
  always @(posedge write_strobe_n_i) if (!chip_select_n_i) begin
    if (cle_i && (busy == 0 || io_i inside {8'hff, 8'h70, 8'h71})) begin
      cmd = io_i;
      acyc = 0;
      case (io_i)
        8'h00, 8'h01, 8'h50: begin
          addr[8] = io_i[0];
          mode = 0;
        end
        8'h80: mode = 0;
        8'h10, 8'h11, 8'h15, 8'hd0: begin
          fail = !write_guard_n_i;
          if (write_guard_n_i) busy = io_i == 8'h11 ? 4 : BUSY_CYC;
          if (write_guard_n_i && io_i inside {8'h10, 8'h15})
            foreach (page[i]) mem[addr[25:9] * 528 + i] = page[i];
        end
        8'h70, 8'h71: mode = 1;
        8'h90, 8'h91: mode = 2;
        8'hff: begin
          busy = 2;
          fail = 1'b0;
        end
        default: ;
      endcase
    end else if (ale_i) begin
      case (acyc)
        0: addr[7:0] = io_i;
        1: addr[16:9] = io_i;
        2: addr[24:17] = io_i;
        default: a4 = io_i;
      endcase
      if (acyc == 3) addr[25] = io_i[0];
      col = int'({cmd != 8'h80 && addr[8], addr[7:0]});
      acyc++;
      if (acyc == 4 && cmd inside {8'h00, 8'h01, 8'h50}) begin
        busy = BUSY_CYC;
        foreach (page[i])
          page[i] = mem.exists(addr[25:9] * 528 + i) ? mem[addr[25:9] * 528 + i] : 8'hff;
      end
    end else if (write_guard_n_i) begin
      page[col % 528] = io_i;
      col++;
    end
  end
  always @(negedge read_strobe_n_i) if (!chip_select_n_i) begin
    case (mode)
      1: io_o = {write_guard_n_i, busy == 0, 5'h00, fail};
      2: io_o = MAKER_ID;
      default: begin
        io_o = page[col % 528];
        col++;
      end
    endcase
  end
endmodule : nand_dev_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the nand host with a device model
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [31:0] ADR = 32'h0255_a605;
  localparam logic [7:0]  ID_CODE = 8'h3c;  // arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o, cle_o, ale_o, cs_n, we_n, re_n, wp_n, host_oe, dev_oe, rb_n;
  logic [7:0]  host_io, dev_io;
  logic [7:0]  last = 8'h00;
  wire  logic [7:0] bus = host_oe ? host_io : dev_oe ? dev_io : ~last;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (host_oe || dev_oe) last <= bus;
  nand_host dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .cle_o, .ale_o, .chip_select_n_o(cs_n), .write_strobe_n_o(we_n),
    .read_strobe_n_o(re_n), .write_guard_n_o(wp_n), .io_o(host_io), .io_oe_o(host_oe),
    .io_i(bus), .ready_busy_n_i(rb_n));
  nand_dev_model #(.MAKER_ID(ID_CODE)) dev_u (.clk_i, .cle_i(cle_o), .ale_i(ale_o),
    .chip_select_n_i(cs_n), .write_strobe_n_i(we_n), .read_strobe_n_i(re_n),
    .write_guard_n_i(wp_n), .io_i(bus), .io_o(dev_io), .io_oe_o(dev_oe), .ready_busy_n_o(rb_n));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // f holds keep chip select and guard level
  task automatic op(input logic [3:0] k, input logic [7:0] c, input logic [1:0] f);
    logic [31:0] q;
    int n;
    n = 0;
    wb(nand_host_pkg::REG_CTRL, 1'b1, {17'h0, f, 1'b1, k, c}, q);
    do begin
      wb(nand_host_pkg::REG_STATUS, 1'b0, 32'h0, q);
      n++;
    end while (q[3:0] !== 4'h0 && n < 500);
  endtask : op
  task automatic rd(output logic [7:0] b);
    logic [31:0] q;
    op(nand_host_pkg::KIND_READ, 8'h00, 2'b11);
    wb(nand_host_pkg::REG_DATA, 1'b0, 32'h0, q);
    b = q[7:0];
  endtask : rd
  task automatic status(input logic [7:0] exp);
    logic [7:0] b;
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_STATUS1, 2'b11);
    rd(b);
    chk("status byte", exp, b);
  endtask : status
  task automatic t_regs;
    logic [31:0] q;
    wb(nand_host_pkg::REG_STATUS, 1'b0, 32'h0, q);
    chk("idle state", 32'h0, {28'h0, q[3:0]});
    wb(4'h2, 1'b1, 32'hffff_ffff, q);
    wb(4'h2, 1'b0, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    $display("test regs done");
  endtask : t_regs
  task automatic t_program;
    logic [7:0]  b;
    logic [31:0] q;
    wb(nand_host_pkg::REG_ADDR, 1'b1, ADR, q);
    op(nand_host_pkg::KIND_CMD_ADDR, nand_host_pkg::CMD_DATA_IN, 2'b01);
    chk("address cycles", {6'h0, ADR[25:0]}, {6'h0, dev_u.addr});
    chk("fourth cycle lines", 32'h0, {25'h0, dev_u.a4[7:1]});
    for (int i = 0; i < 2; i++) begin
      wb(nand_host_pkg::REG_DATA, 1'b1, {24'h0, i ? 8'h5a : 8'ha5}, q);
      op(nand_host_pkg::KIND_WRITE, 8'h00, 2'b01);
    end
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_PROG_TRUE, 2'b01);
    status(8'hc0);
    for (int r = 0; r < 2; r++) begin
      op(nand_host_pkg::KIND_CMD_ADDR, r ? 8'h01 : 8'h00, 2'b11);
      chk("column bit 8", r, {31'h0, dev_u.addr[8]});
      op(nand_host_pkg::KIND_WAIT, 8'h00, 2'b11);
      rd(b);
      chk("first byte", r ? 8'hff : 8'ha5, b);
      rd(b);
      chk("second byte", r ? 8'hff : 8'h5a, b);
    end
    $display("test program done");
  endtask : t_program
  task automatic t_misc;
    logic [7:0]  b;
    logic [31:0] q;
    logic [7:0]  cmds [7] = '{8'h50, 8'h11, 8'h15, 8'h60, 8'hd0, 8'h71, 8'h91};
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_PROG_TRUE, 2'b00);
    status(8'hc1);
    op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_RESET, 2'b01);
    status(8'hc0);
    wb(nand_host_pkg::REG_ADDR, 1'b1, 32'h0, q);
    op(nand_host_pkg::KIND_ID, nand_host_pkg::CMD_ID1, 2'b11);
    rd(b);
    chk("id byte", ID_CODE, b);
    foreach (cmds[i]) begin
      op(nand_host_pkg::KIND_CMD, cmds[i], 2'b01);
      status(8'hc0);
    end
    for (int i = 0; i < 4; i++) begin
      if (i == 3) op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_STATUS1, 2'b01);
      op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_PROG_TRUE, 2'b01);
    end
    chk("fourth page program", nand_host_pkg::CMD_STATUS1, dev_u.cmd);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_STATUS1, 2'b01);
      op(nand_host_pkg::KIND_CMD, nand_host_pkg::CMD_PROG_DUMMY, 2'b01);
    end
    chk("fifth multi block", nand_host_pkg::CMD_STATUS1, dev_u.cmd);
    $display("test misc done");
  endtask : t_misc
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_program();
    t_misc();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
